/* File: core/position_frame_decoder.sv */
// Device end: decodes absolute positioning frames into target updates
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
`include "posdec_params.svh"
module position_frame_decoder (
  // Clock, reset, enable
  input  wire logic        CLK_SYS_I,
  input  wire logic        NRST_I,
  input  wire logic        CE_I,
  // Frame link
  frame_link_if.slave_end  FRAME,
  // Node identity and identifier allocation
  input  wire logic [6:0]  NODE_ADDRESS_I,
  input  wire logic [3:0]  STORED_NODE_ADDRESS_I,
  input  wire logic [5:0]  DIRECT_ID_I,
  input  wire logic [5:0]  GP4_ID_I,
  input  wire logic [5:0]  COMPACT2_ID_I,
  input  wire logic [5:0]  COMPACT4_ID_I,
  input  wire logic [5:0]  COMPACT8_ID_I,
  // Priority logic
  input  wire logic        POSITIONING_BLOCKED_I,
  // Target update to the position controller
  output logic      [15:0] TARGET_O,
  output logic             TARGET_VALID_O,
  output logic      [1:0]  MOTOR_INDEX_O,
  output logic             COMPACT_O,
  output logic             PARITY_ERROR_O,
  output logic             DISCARDED_O
);

  posdec_pkg::decoder_state_type state_reg;
  posdec_pkg::decoder_state_type state_next;

  // Frame bytes and identifier checks
  logic [7:0]  byte_at [0:7];
  logic [5:0]  id;
  logic        take;
  logic        parity_low;
  logic        parity_high;
  logic        parity_ok;
  // Match result of the current frame
  logic        hit;
  logic [15:0] hit_target;
  logic [1:0]  hit_index;
  logic        hit_compact;
  // Compact frame group walk
  logic [2:0]  groups;
  logic        compact_frame;
  logic [7:0]  grp_hi;

  // Byte lanes of the frame, byte one first
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bytes
      // Byte 1 of the frame sits in the top lane
      assign byte_at[gi] = FRAME.data[63 - 8 * gi -: 8];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // Identifier without its two parity bits
    id = FRAME.pid[5:0];
    take = FRAME.valid & CE_I;
    // Parity bits recomputed here rather than trusted from the link
    parity_low = id[0] ^ id[1] ^ id[2] ^ id[4];
    parity_high = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    parity_ok = (FRAME.pid[6] == parity_low) && (FRAME.pid[7] == parity_high);

    // Defaults keep the match clear for frames that miss
    hit = 1'b0;
    hit_target = 16'h0000;
    hit_index = 2'h0;
    hit_compact = 1'b0;
    groups = 3'h0;
    compact_frame = 1'b0;
    grp_hi = 8'h00;

    if (id == `DUAL_FRAME_ID) begin
      // Dual-motor frame on the fixed identifier
      if (FRAME.len == `LEN_EIGHT && byte_at[0] == `APP_CMD_BYTE &&
          byte_at[1] == {1'b1, `POS_CMD_CODE} && byte_at[2][7] &&
          byte_at[5][7]) begin
        // First address has priority over the second
        if (byte_at[2][6:0] == NODE_ADDRESS_I) begin
          hit = 1'b1;
          hit_target = {byte_at[3], byte_at[4]};
          hit_index = 2'h0;
        end else if (byte_at[5][6:0] == NODE_ADDRESS_I) begin
          hit = 1'b1;
          hit_target = {byte_at[6], byte_at[7]};
          hit_index = 2'h1;
        end
      end
    end else if (id == DIRECT_ID_I && !id[5]) begin
      // Identifier is this node's own, so no address field exists
      if (FRAME.len == `LEN_TWO) begin
        hit = 1'b1;
        hit_target = {byte_at[0], byte_at[1]};
      end
    end else if (id == GP4_ID_I && id[5:4] == `GP4_ID_TOP) begin
      // Broadcast flag low means every node takes it
      if (FRAME.len == `LEN_FOUR && byte_at[0] == {1'b1, `POS_CMD_CODE}) begin
        if (!byte_at[1][7] || byte_at[1][6:0] == NODE_ADDRESS_I) begin
          hit = 1'b1;
          hit_target = {byte_at[2], byte_at[3]};
        end
      end
    end else if (id == COMPACT2_ID_I && !id[5] && FRAME.len == `LEN_TWO) begin
      // Single compact group, broadcast allowed
      groups = 3'h1;
      compact_frame = 1'b1;
    end else if (id == COMPACT4_ID_I && id[5:4] == `GP4_ID_TOP &&
                 FRAME.len == `LEN_FOUR) begin
      // Two groups, each with its own address
      groups = 3'h2;
      compact_frame = 1'b1;
    end else if (id == COMPACT8_ID_I && id[5:4] == `QUAD_ID_TOP &&
                 FRAME.len == `LEN_EIGHT) begin
      // Four groups on eight bytes
      groups = 3'h4;
      compact_frame = 1'b1;
    end

    // Walk the groups from last to first
    if (compact_frame) begin
      // Lowest matching group wins if the master repeats an address
      for (int k = 3; k >= 0; k--) begin
        grp_hi = byte_at[2 * k];
        // Groups past the frame length are skipped
        if (3'(k) < groups) begin
          if ((groups == 3'h1 && !grp_hi[4]) ||
              (grp_hi[4] && grp_hi[3:0] == STORED_NODE_ADDRESS_I)) begin
            hit = 1'b1;
            // Half steps scaled onto the full range keep the sign
            hit_target = {grp_hi[7:5], byte_at[2 * k + 1],
                          {(`FULL_POS_W - `COMPACT_POS_W){1'b0}}};
            hit_index = 2'(k);
            hit_compact = 1'b1;
          end
        end
      end
    end

    // Parity first, then priority, then the update itself
    state_next = state_reg;
    state_next.target_valid = 1'b0;
    state_next.parity_error = 1'b0;
    state_next.discarded = 1'b0;
    // Nothing but the pulses changes unless a frame is taken
    if (take) begin
      // A bad identifier never reaches the priority check
      if (!parity_ok) begin
        state_next.parity_error = 1'b1;
      end else if (hit && POSITIONING_BLOCKED_I) begin
        state_next.discarded = 1'b1;
      end else if (hit) begin
        state_next.target = hit_target;
        state_next.target_valid = 1'b1;
        state_next.motor_index = hit_index;
        state_next.compact = hit_compact;
      end
      // Frames for other nodes fall through with the target held
    end
  end

  // All state frozen while the clock enable is low
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg <= '0;
    end else if (CE_I) begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The link is accepted whenever the clock runs, so no frame waits
  // Pulses last one cycle; the target holds until the next update
  assign FRAME.ready    = CE_I;
  assign TARGET_O       = state_reg.target;
  assign TARGET_VALID_O = state_reg.target_valid;
  assign MOTOR_INDEX_O  = state_reg.motor_index;
  assign COMPACT_O      = state_reg.compact;
  assign PARITY_ERROR_O = state_reg.parity_error;
  assign DISCARDED_O    = state_reg.discarded;

endmodule : position_frame_decoder

/* File: core/posdec_params.svh */
// Constant values shared by the positioning frame ends
`ifndef POSDEC_PARAMS_SVH
`define POSDEC_PARAMS_SVH

// Frame content
`define POS_CMD_CODE        7'h0B
`define APP_CMD_BYTE        8'h80
`define DUAL_FRAME_ID       6'h3C
`define GP4_ID_TOP          2'h2
`define QUAD_ID_TOP         2'h3
`define FULL_POS_W          16
`define COMPACT_POS_W       11
`define LEN_TWO             4'h2
`define LEN_FOUR            4'h4
`define LEN_EIGHT           4'h8

// Controller register offsets
`define REG_CTRL_OFS        12'h000
`define REG_PID_OFS         12'h004
`define REG_DATA_HI_OFS     12'h008
`define REG_DATA_LO_OFS     12'h00C
`define REG_STATUS_OFS      12'h010

// Controller register fields
`define CTRL_START_BIT      0
`define CTRL_LEN_LSB        8
`define STATUS_BUSY_BIT     0
`define STATUS_DONE_BIT     1
`define DONE_CLEAR_BIT      1

// Reset values
`define PID_RESET           6'h00
`define LEN_RESET           4'h2

`endif

/* File: core/posdec_pkg.sv */
// Types shared by the positioning frame ends
package posdec_pkg;

  typedef enum logic [1:0] {
    M_IDLE = 2'b01,
    M_SEND = 2'b10
  } master_state_type;

  typedef struct packed {
    logic [15:0] target;
    logic        target_valid;
    logic [1:0]  motor_index;
    logic        compact;
    logic        parity_error;
    logic        discarded;
  } decoder_state_type;

  typedef struct packed {
    master_state_type state;
    logic [5:0]       pid;
    logic [3:0]       len;
    logic [63:0]      data;
    logic             done;
    logic [31:0]      prdata;
  } master_regs_type;

endpackage : posdec_pkg

/* File: core/frame_link_if.sv */
// Frame level link between the bus master and the positioning decoder
`timescale 1ns/1ns
interface frame_link_if;
  logic        valid;
  logic        ready;
  logic [7:0]  pid;
  logic [3:0]  len;
  logic [63:0] data;

  modport slave_end (
    input  valid,
    input  pid,
    input  len,
    input  data,
    output ready
  );

  modport master_end (
    output valid,
    output pid,
    output len,
    output data,
    input  ready
  );
endinterface : frame_link_if

/* File: core/frame_master_apb.sv */
// Bus master end: APB registers that compose and send positioning frames
`timescale 1ns/1ns
`include "posdec_params.svh"
module frame_master_apb (
  // Clock, reset, enable
  input  wire logic        CLK_SYS_I,
  input  wire logic        NRST_I,
  input  wire logic        CE_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Frame link
  frame_link_if.master_end FRAME
);

  posdec_pkg::master_regs_type state_reg;
  posdec_pkg::master_regs_type state_next;

  logic access;
  logic wr;
  logic rd;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    access = PSEL_I & PENABLE_I;
    wr = access & PWRITE_I;
    rd = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    mapped = 1'b0;
    state_next = state_reg;
    if (PADDR_I == `REG_CTRL_OFS) begin
      mapped = 1'b1;
    end else if (PADDR_I == `REG_PID_OFS) begin
      mapped = 1'b1;
    end else if (PADDR_I == `REG_DATA_HI_OFS) begin
      mapped = 1'b1;
    end else if (PADDR_I == `REG_DATA_LO_OFS) begin
      mapped = 1'b1;
    end else if (PADDR_I == `REG_STATUS_OFS) begin
      mapped = 1'b1;
    end
    // Frame contents are frozen while a frame is on the link
    if (wr && state_reg.state == posdec_pkg::M_IDLE) begin
      if (PADDR_I == `REG_PID_OFS) begin
        state_next.pid = PWDATA_I[5:0];
      end else if (PADDR_I == `REG_DATA_HI_OFS) begin
        state_next.data[63:32] = PWDATA_I;
      end else if (PADDR_I == `REG_DATA_LO_OFS) begin
        state_next.data[31:0] = PWDATA_I;
      end else if (PADDR_I == `REG_CTRL_OFS) begin
        state_next.len = PWDATA_I[`CTRL_LEN_LSB +: 4];
        if (PWDATA_I[`CTRL_START_BIT]) begin
          state_next.state = posdec_pkg::M_SEND;
        end
      end
    end
    if (wr && PADDR_I == `REG_STATUS_OFS && PWDATA_I[`DONE_CLEAR_BIT]) begin
      state_next.done = 1'b0;
    end
    case (state_reg.state)
      posdec_pkg::M_SEND: begin
        if (FRAME.ready) begin
          state_next.state = posdec_pkg::M_IDLE;
          // Completion beats a clear in the same cycle
          state_next.done = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // Read data is captured in the setup cycle and stands through the access phase
    if (!access) begin
      state_next.prdata = 32'h0000_0000;
    end
    if (rd) begin
      if (PADDR_I == `REG_CTRL_OFS) begin
        state_next.prdata[`CTRL_LEN_LSB +: 4] = state_reg.len;
      end else if (PADDR_I == `REG_PID_OFS) begin
        state_next.prdata[5:0] = state_reg.pid;
      end else if (PADDR_I == `REG_DATA_HI_OFS) begin
        state_next.prdata = state_reg.data[63:32];
      end else if (PADDR_I == `REG_DATA_LO_OFS) begin
        state_next.prdata = state_reg.data[31:0];
      end else if (PADDR_I == `REG_STATUS_OFS) begin
        state_next.prdata[`STATUS_BUSY_BIT] = (state_reg.state == posdec_pkg::M_SEND);
        state_next.prdata[`STATUS_DONE_BIT] = state_reg.done;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg.state  <= posdec_pkg::M_IDLE;
      state_reg.pid    <= `PID_RESET;
      state_reg.len    <= `LEN_RESET;
      state_reg.data   <= 64'h0000_0000_0000_0000;
      state_reg.done   <= 1'b0;
      state_reg.prdata <= 32'h0000_0000;
    end else if (CE_I) begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is registered at setup, so no wait state is needed
  assign PREADY_O  = PSEL_I & PENABLE_I & CE_I;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
  assign PRDATA_O  = state_reg.prdata;

  assign FRAME.valid = (state_reg.state == posdec_pkg::M_SEND);
  assign FRAME.len   = state_reg.len;
  assign FRAME.data  = state_reg.data;
  // Protected identifier parity on the top two bits
  assign FRAME.pid   = {~(state_reg.pid[1] ^ state_reg.pid[3] ^ state_reg.pid[4] ^
                          state_reg.pid[5]),
                        state_reg.pid[0] ^ state_reg.pid[1] ^ state_reg.pid[2] ^
                          state_reg.pid[4],
                        state_reg.pid};

endmodule : frame_master_apb

/* File: sim/frame_link_chk.sv */
// Assertions on the positioning frame link and the decoder outputs
`timescale 1ns/1ns
module frame_link_chk (
  // Clock and reset
  input wire logic        CLK_SYS_I,
  input wire logic        NRST_I,
  // Link
  input wire logic        valid,
  input wire logic        ready,
  input wire logic [7:0]  pid,
  input wire logic [3:0]  len,
  input wire logic [63:0] data,
  // Decoder side
  input wire logic [6:0]  NODE_ADDRESS_I,
  input wire logic        POSITIONING_BLOCKED_I,
  input wire logic [15:0] TARGET_O,
  input wire logic        TARGET_VALID_O,
  input wire logic [1:0]  MOTOR_INDEX_O,
  input wire logic        COMPACT_O,
  input wire logic        PARITY_ERROR_O,
  input wire logic        DISCARDED_O
);
  logic        take;
  logic        dual;
  logic        hit1;
  logic        hit2;
  logic [63:0] data_q;
  assign take = valid && ready;
  assign dual = take && pid[5:0] == 6'h3C && len == 4'h8 && data[63:48] == 16'h808B
                && !POSITIONING_BLOCKED_I;
  assign hit1 = data[47:40] == {1'b1, NODE_ADDRESS_I};
  assign hit2 = data[23:16] == {1'b1, NODE_ADDRESS_I};
  // Frame copy lets the answer one cycle later be tied to the taken payload
  always_ff @(posedge CLK_SYS_I) begin
    data_q <= data;
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  a_id_parity: assert property (valid |-> pid[6] == ^{pid[4], pid[2:0]}
    && pid[7] == ~^{pid[5:3], pid[1]}) else $error("identifier parity wrong");
  a_no_parity_err: assert property (take |=> !PARITY_ERROR_O)
    else $error("parity error on a good frame");
  a_dual_first: assert property (dual && hit1 |=> TARGET_VALID_O
    && TARGET_O == data_q[39:24] && MOTOR_INDEX_O == 2'h0) else $error("dual first wrong");
  a_dual_second: assert property (dual && !hit1 && hit2 |=> TARGET_VALID_O
    && TARGET_O == data_q[15:0] && MOTOR_INDEX_O == 2'h1) else $error("dual second wrong");
  a_dual_miss: assert property (dual && !hit1 && !hit2 |=> !TARGET_VALID_O)
    else $error("unaddressed dual frame applied");
  a_blocked_quiet: assert property (take && POSITIONING_BLOCKED_I |=> !TARGET_VALID_O)
    else $error("blocked frame applied");
  a_discard_cause: assert property (DISCARDED_O |-> $past(take)
    && $past(POSITIONING_BLOCKED_I)) else $error("discard without blocked frame");
  a_update_cause: assert property (TARGET_VALID_O |-> $past(take) && !DISCARDED_O)
    else $error("update without frame");
  a_half_step: assert property (TARGET_VALID_O && COMPACT_O |-> TARGET_O[4:0] == 5'h00)
    else $error("compact target off half step");
  a_target_hold: assert property (!TARGET_VALID_O |-> $stable(TARGET_O))
    else $error("target moved without update");
  c_dual_second: cover property (dual && !hit1 && hit2);
  c_compact: cover property (TARGET_VALID_O && COMPACT_O);
  c_discard: cover property (DISCARDED_O);
endmodule : frame_link_chk

/* File: sim/tb.sv */
// Self-checking bench: APB master end driving the positioning decoder
`timescale 1ns/1ns
`include "posdec_params.svh"
module tb;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, serr, tv, cmp, perr, disc;
  logic        blocked = 1'b0;
  logic [6:0]  node = 7'h00;
  logic [5:0]  dir_id = 6'h00, c2_id = 6'h01, gp4_id = 6'h20, c4_id = 6'h21, c8_id = 6'h30;
  logic [15:0] tgt, last = 16'h0;
  logic [1:0]  idx;
  int          err_total = 0, checks = 0, cyc = 0;
  frame_link_if lnk();
  frame_master_apb u_frame_master_apb (.CLK_SYS_I(clk_sys), .NRST_I(nrst), .CE_I(1'b1),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .FRAME(lnk));
  position_frame_decoder u_position_frame_decoder (.CLK_SYS_I(clk_sys), .NRST_I(nrst),
    .CE_I(1'b1), .FRAME(lnk), .NODE_ADDRESS_I(node), .STORED_NODE_ADDRESS_I(node[3:0]),
    .DIRECT_ID_I(dir_id), .GP4_ID_I(gp4_id), .COMPACT2_ID_I(c2_id), .COMPACT4_ID_I(c4_id),
    .COMPACT8_ID_I(c8_id), .POSITIONING_BLOCKED_I(blocked), .TARGET_O(tgt),
    .TARGET_VALID_O(tv), .MOTOR_INDEX_O(idx), .COMPACT_O(cmp), .PARITY_ERROR_O(perr),
    .DISCARDED_O(disc));
  frame_link_chk u_frame_link_chk (.CLK_SYS_I(clk_sys), .NRST_I(nrst), .valid(lnk.valid),
    .ready(lnk.ready), .pid(lnk.pid), .len(lnk.len), .data(lnk.data), .NODE_ADDRESS_I(node),
    .POSITIONING_BLOCKED_I(blocked), .TARGET_O(tgt), .TARGET_VALID_O(tv),
    .MOTOR_INDEX_O(idx), .COMPACT_O(cmp), .PARITY_ERROR_O(perr), .DISCARDED_O(disc));
  always #2 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////
  task give_verdict();
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  // A hung handshake would otherwise stall the run forever
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Entered just after an edge; read data and error are taken at the accepting edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    serr = pslverr;
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  // Returns {hit, compact, index, target}
  function automatic logic [19:0] model(input logic [5:0] id, input logic [3:0] n,
                                        input logic [63:0] d);
    logic [7:0] b [8];
    model = 20'h0;
    for (int k = 0; k < 8; k++) b[k] = d[63 - 8 * k -: 8];
    if (id == dir_id && n == 4'h2)
      model = {4'h8, b[0], b[1]};
    else if (id == gp4_id && n == 4'h4 && b[0] == 8'h8B && (!b[1][7] || b[1][6:0] == node))
      model = {4'h8, b[2], b[3]};
    else if (id == 6'h3C && n == 4'h8 && b[0] == 8'h80 && b[1] == 8'h8B) begin
      if (b[2] == {1'b1, node}) model = {4'h8, b[3], b[4]};
      else if (b[5] == {1'b1, node}) model = {4'h9, b[6], b[7]};
    end else if (id == c2_id && n == 4'h2 && (!b[0][4] || b[0][3:0] == node[3:0]))
      model = {4'hC, b[0][7:5], b[1], 5'h00};
    else if ((id == c4_id && n == 4'h4) || (id == c8_id && n == 4'h8))
      for (int g = 3; g >= 0; g--)
        if (g < n / 2 && b[2 * g][4] && b[2 * g][3:0] == node[3:0])
          model = {2'b11, 2'(g), b[2 * g][7:5], b[2 * g + 1], 5'h00};
  endfunction : model
  task run(input logic [5:0] id, input logic [3:0] n, input logic [63:0] d);
    logic [19:0] e;
    logic [19:0] got;
    logic        dsc;
    e = model(id, n, d);
    got = 20'h0;
    dsc = 1'b0;
    blocked <= ($urandom_range(0, 5) == 0);
    apb(1'b1, `REG_PID_OFS, {26'h0, id});
    apb(1'b1, `REG_DATA_HI_OFS, d[63:32]);
    apb(1'b1, `REG_DATA_LO_OFS, d[31:0]);
    apb(1'b1, `REG_CTRL_OFS, {20'h0, n, 8'h01});
    repeat (5) begin
      @(posedge clk_sys);
      if (tv === 1'b1) got = {1'b1, cmp, idx, tgt};
      if (disc === 1'b1) dsc = 1'b1;
    end
    chk("update", blocked ? 20'h0 : e, got);
    chk("discard", 20'(e[19] && blocked), 20'(dsc));
    if (got === 20'h0) chk("held target", 20'(last), 20'(tgt));
    else last = got[15:0];
  endtask : run
  ////////////////////////////////////////////////////////////
  initial begin
    logic [63:0] r;
    logic [6:0]  ad, a2;
    logic [3:0]  r4;
    void'($urandom(32'hC24B65F2));
    r4 = 4'($urandom_range(0, 11));
    @(posedge clk_sys);
    node <= 7'($urandom);
    dir_id <= {1'b0, r4, 1'b0};
    c2_id <= {1'b0, r4, 1'b1};
    gp4_id <= {2'b10, r4};
    c4_id <= {2'b10, r4 ^ 4'h1};
    c8_id <= {2'b11, r4};
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 70; i++) begin
      r = {$urandom, $urandom};
      ad = ($urandom_range(0, 2) == 0) ? 7'($urandom) : node;
      a2 = ($urandom_range(0, 1) == 0) ? 7'($urandom) : node;
      for (int g = 0; g < 4; g++) begin
        r[60 - 16 * g] = ($urandom_range(0, 3) != 0);
        r[59 - 16 * g -: 4] = ($urandom_range(0, 3) == 0) ? node[3:0] : 4'($urandom);
      end
      case (i % 7)
        0: run(dir_id, 4'h2, r);
        1: run(gp4_id, 4'h4, {8'h8B, 1'($urandom), ad, r[47:0]});
        2: run(6'h3C, 4'h8, {16'h808B, 1'b1, ad, r[47:32], 1'b1, a2, r[15:0]});
        3: run(c2_id, 4'h2, r);
        4: run(c4_id, 4'h4, r);
        5: run(c8_id, 4'h8, r);
        default: run(gp4_id, 4'h8, r);
      endcase
    end
    apb(1'b0, `REG_STATUS_OFS, 32'h0);
    chk("done flag", 20'h2, 20'(rdata[1:0]));
    apb(1'b1, `REG_STATUS_OFS, 32'h2);
    apb(1'b0, `REG_STATUS_OFS, 32'h0);
    chk("done cleared", 20'h0, 20'(rdata[1:0]));
    apb(1'b1, 12'h020, 32'h0);
    chk("unmapped error", 20'h1, 20'(serr));
    give_verdict();
  end
endmodule : tb
